/* File: include/uartfe_pkg.sv */
// Behaviour
// R1 - System reset returns every port register to its default value.
// R2 - Writes to unused locations or bits are ignored; such reads return zero.
// R3 - Software writes zero into every unused bit position.
// R4 - Short characters transmit only the low-order bits of the written byte.
// R5 - Transmit-holding writes push the transmit FIFO; up to 16 bytes when enabled.
// R6 - With FIFOs disabled, transmit and receive buffers each hold one byte.
// R7 - Receive-buffer reads pop the receive FIFO; address shared with transmit and divisor.
// R8 - Short received characters sit in low bits; upper unused bits read zero.
// R9 - Enable bit 4 raises transmission-complete when holding and shifter are empty.
// R10 - Enable bit 3 raises modem-status interrupt on any modem input edge.
// R11 - Enable bit 2 raises line-status interrupt on parity, framing, overrun, break.
// R12 - Enable bit 1 raises transmit interrupt when FIFO or buffer becomes empty.
// R13 - Enable bit 0 raises receive-ready interrupt and also receiver time-out interrupt.
// R14 - Identification bit 7 reads 1 while FIFOs enabled, else 0.
// R15 - Identification bit 0 reads 0 while any source active, else 1.
// R16 - Only the highest-priority active enabled source is reported.
// R17 - Codes: line status 011, receive data 010, time-out 110.
// R18 - Codes: transmission complete 101, transmit empty 001, modem status 000.
// R19 - Divisor bytes reached at shared addresses only while line-control bit 7 is set.
// R20 - Identification shares address with FIFO control; reads status, writes control.
// R21 - Code meaningful only while pending; request output follows any enabled active source.
// R22 - Transmit-empty clears on new write; receive-data clears below trigger.
package uartfe_pkg;
    localparam logic [7:0] ADDR_DATA   = 8'hc0;
    localparam logic [7:0] ADDR_IRQEN  = 8'hc1;
    localparam logic [7:0] ADDR_IDENT  = 8'hc2;
    localparam logic [7:0] ADDR_LINE   = 8'hc3;
    localparam logic [7:0] IRQEN_RST   = 8'h00;
    localparam logic [7:0] IDENT_RST   = 8'h01;
    localparam logic [7:0] FIFOCTL_RST = 8'h00;
    localparam logic [7:0] LINECTL_RST = 8'h00;
    localparam logic [7:0] DIVLO_RST   = 8'h02;
    localparam logic [7:0] DIVHI_RST   = 8'h00;
    localparam int IRQEN_BITS   = 5;
    localparam int TXC_BIT      = 4;
    localparam int MODEM_BIT    = 3;
    localparam int LINE_BIT     = 2;
    localparam int TXE_BIT      = 1;
    localparam int RXR_BIT      = 0;
    localparam int FIFO_ON_BIT  = 7;
    localparam int DLAB_BIT     = 7;
    localparam int FIFOEN_BIT   = 0;
    localparam int RXEN_BIT     = 1;
    localparam int TXEN_BIT     = 2;
    localparam int TRIG_LSB     = 6;
    localparam int WLEN_LSB     = 0;
    localparam int FIFO_DEPTH   = 16;
    localparam logic [2:0] CODE_LINE  = 3'h3;
    localparam logic [2:0] CODE_RXRDY = 3'h2;
    localparam logic [2:0] CODE_TOUT  = 3'h6;
    localparam logic [2:0] CODE_TXC   = 3'h5;
    localparam logic [2:0] CODE_TXE   = 3'h1;
    localparam logic [2:0] CODE_MODEM = 3'h0;
    localparam logic [4:0] TRIG_1  = 5'h01;
    localparam logic [4:0] TRIG_4  = 5'h04;
    localparam logic [4:0] TRIG_8  = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0e;
endpackage

/* File: rtl/uartfe_fifo.sv */
`timescale 1ns/10ps
// Byte queue; depth limit may be lowered to one at run time
module uartfe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    input  wire logic                       flush_i,
    input  wire logic                       one_deep_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [WIDTH-1:0]                out_data_o,
    output logic [$clog2(DEPTH+1)-1:0]      count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    rd_ff;
    logic [AW-1:0]    wr_ff;
    logic [CW-1:0]    cnt_ff;
    logic [CW-1:0]    limit;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign limit       = one_deep_i ? CW'(1) : CW'(DEPTH);
    assign in_ready_o  = cnt_ff < limit;
    assign out_valid_o = cnt_ff != '0;
    assign out_data_o  = mem[rd_ff];
    assign count_o     = cnt_ff;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || flush_i) begin
            rd_ff  <= '0;
            wr_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + AW'(1);
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + AW'(1);
            end
            cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
        end
    end

    a_no_overfill: assert property (@(posedge clk_i) disable iff (reset_i)
        cnt_ff <= limit || $past(one_deep_i) != one_deep_i)
        else $error("fifo count above limit");
endmodule

/* File: rtl/uartfe_regs.sv */
`timescale 1ns/10ps
module uartfe_regs
    import uartfe_pkg::*;
#(
    parameter int DEPTH = uartfe_pkg::FIFO_DEPTH
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // CPU I/O port
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic [7:0]      rdata_o,
    // Transmit shifter side
    output logic            tx_valid_o,
    input  wire logic       tx_ready_i,
    output logic [7:0]      tx_data_o,
    input  wire logic       tx_shift_empty_i,
    // Receive shifter side
    input  wire logic       rx_valid_i,
    output logic            rx_ready_o,
    input  wire logic [7:0] rx_data_i,
    input  wire logic       rx_timeout_i,
    input  wire logic       rx_line_err_i,
    // Modem status inputs from pins
    input  wire logic [3:0] modem_i,
    // Configuration to the rest of the port
    output logic [15:0]     divisor_o,
    output logic            divisor_load_o,
    output logic [7:0]      line_control_o,
    output logic            irq_o
);
    import uartfe_pkg::*;

    logic [7:0] irq_en_ff;
    logic [7:0] fifo_ctl_ff;
    logic [7:0] line_ctl_ff;
    logic [7:0] div_lo_ff;
    logic [7:0] div_hi_ff;
    logic [7:0] rdata_ff;
    logic       line_pend_ff;
    logic       modem_pend_ff;
    logic       txe_pend_ff;
    logic       txc_pend_ff;
    logic       tx_was_busy_ff;
    logic [3:0] modem_s1_ff;
    logic [3:0] modem_s2_ff;
    logic [3:0] modem_s3_ff;

    // Address decode; divisor latch overlays data and enable
    wire dlab      = line_ctl_ff[DLAB_BIT];
    wire sel_data  = addr_i == ADDR_DATA;
    wire sel_irqen = addr_i == ADDR_IRQEN;
    wire sel_ident = addr_i == ADDR_IDENT;
    wire sel_line  = addr_i == ADDR_LINE;
    wire wr_thr    = wr_i && sel_data && !dlab;                                          // R19
    wire wr_divlo  = wr_i && sel_data && dlab;                                           // R19
    wire wr_divhi  = wr_i && sel_irqen && dlab;                                          // R19
    wire wr_irqen  = wr_i && sel_irqen && !dlab;                                         // R19
    wire wr_fifo_control   = wr_i && sel_ident;                                                  // R20
    wire wr_line_control   = wr_i && sel_line;
    wire rd_rbr    = rd_i && sel_data && !dlab;                                          // R7

    wire fifo_on = fifo_ctl_ff[FIFOEN_BIT];
    wire one_deep = !fifo_on;                                                            // R6

    // Character length mask: 5 to 8 bits
    logic [7:0] len_mask;
    assign len_mask = 8'hff >> (2'h3 - line_ctl_ff[WLEN_LSB +: 2]);

    // Transmit and receive queues
    logic       txq_ready;
    logic [4:0] tx_count;
    logic [4:0] rx_count;
    logic [7:0] rx_head;
    logic       rxq_valid;
    wire        tx_flush = fifo_on && !fifo_ctl_ff[TXEN_BIT];
    wire        rx_flush = fifo_on && !fifo_ctl_ff[RXEN_BIT];

    uartfe_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .flush_i     (tx_flush),
        .one_deep_i  (one_deep),
        .in_valid_i  (wr_thr),                                                           // R5
        .in_ready_o  (txq_ready),
        .in_data_i   (wdata_i & len_mask),                                               // R4
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (tx_data_o),
        .count_o     (tx_count)
    );

    uartfe_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxq (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .flush_i     (rx_flush),
        .one_deep_i  (one_deep),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_data_i & len_mask),                                             // R8
        .out_valid_o (rxq_valid),
        .out_ready_i (rd_rbr),                                                           // R7
        .out_data_o  (rx_head),
        .count_o     (rx_count)
    );

    // Trigger level applies only with FIFO on
    logic [4:0] trig_lvl;
    always_comb begin
        case (fifo_ctl_ff[TRIG_LSB +: 2])
            2'h0:    trig_lvl = TRIG_1;
            2'h1:    trig_lvl = TRIG_4;
            2'h2:    trig_lvl = TRIG_8;
            default: trig_lvl = TRIG_14;
        endcase
    end
    wire rx_ready_src = fifo_on ? (rx_count >= trig_lvl) : rxq_valid;                   // R22

    // Modem edge detection after two-flop synchroniser
    wire modem_edge = |(modem_s2_ff ^ modem_s3_ff);                                     // R10
    wire tx_empty_now = !tx_valid_o;
    wire tx_idle_now  = tx_empty_now && tx_shift_empty_i;

    // Sources gated by enables
    wire src_line  = line_pend_ff  && irq_en_ff[LINE_BIT];                               // R11
    wire src_rxr   = rx_ready_src  && irq_en_ff[RXR_BIT];                                // R13
    wire src_tout  = rx_timeout_i  && rxq_valid && irq_en_ff[RXR_BIT];                   // R13
    wire src_txc   = txc_pend_ff   && irq_en_ff[TXC_BIT];                                // R9
    wire src_txe   = txe_pend_ff   && irq_en_ff[TXE_BIT];                                // R12
    wire src_modem = modem_pend_ff && irq_en_ff[MODEM_BIT];                              // R10
    wire any_src   = src_line | src_rxr | src_tout | src_txc | src_txe | src_modem;

    logic [2:0] cause;
    always_comb begin
        if (src_line) begin                                                              // R16
            cause = CODE_LINE;                                                           // R17
        end else if (src_rxr) begin
            cause = CODE_RXRDY;                                                          // R17
        end else if (src_tout) begin
            cause = CODE_TOUT;                                                           // R17
        end else if (src_txc) begin
            cause = CODE_TXC;                                                            // R18
        end else if (src_txe) begin
            cause = CODE_TXE;                                                            // R18
        end else begin
            cause = CODE_MODEM;                                                          // R18
        end
    end

    // Code forced to zero when idle so stale causes never show
    logic [7:0] ident_val;
    assign ident_val = {fifo_on, 3'h0, any_src ? cause : 3'h0, !any_src};               // R14 R15 R21
    assign irq_o = any_src;                                                              // R21

    // Reading the identification register services transmit-type sources
    wire rd_ident = rd_i && sel_ident;
    wire ack_txe  = rd_ident && any_src && cause == CODE_TXE;
    wire ack_txc  = rd_ident && any_src && cause == CODE_TXC;
    wire rd_line_control  = rd_i && sel_line;

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;                                                                  // R2
        if (sel_data) begin
            rd_mux = dlab ? div_lo_ff : rx_head;
        end else if (sel_irqen) begin
            rd_mux = dlab ? div_hi_ff : irq_en_ff;
        end else if (sel_ident) begin
            rd_mux = ident_val;
        end else if (sel_line) begin
            rd_mux = line_ctl_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin                                                               // R1
            irq_en_ff   <= IRQEN_RST;
            fifo_ctl_ff <= FIFOCTL_RST;
            line_ctl_ff <= LINECTL_RST;
            div_lo_ff   <= DIVLO_RST;
            div_hi_ff   <= DIVHI_RST;
            rdata_ff    <= 8'h00;
        end else begin
            if (wr_irqen) begin
                irq_en_ff <= {3'h0, wdata_i[IRQEN_BITS-1:0]};                           // R2
            end
            if (wr_fifo_control) begin
                fifo_ctl_ff <= {wdata_i[7:6], 3'h0, wdata_i[2:0]};                       // R2
            end
            if (wr_line_control) begin
                line_ctl_ff <= wdata_i;
            end
            if (wr_divlo) begin
                div_lo_ff <= wdata_i;
            end
            if (wr_divhi) begin
                div_hi_ff <= wdata_i;
            end
            if (rd_i) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // Sticky event sources; set wins over clear, except that wr_thr overrides the txe_pend_ff set
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            line_pend_ff   <= 1'b0;
            modem_pend_ff  <= 1'b0;
            txe_pend_ff    <= 1'b0;
            txc_pend_ff    <= 1'b0;
            tx_was_busy_ff <= 1'b0;
            modem_s1_ff    <= 4'h0;
            modem_s2_ff    <= 4'h0;
            modem_s3_ff    <= 4'h0;
        end else begin
            modem_s1_ff    <= modem_i;
            modem_s2_ff    <= modem_s1_ff;
            modem_s3_ff    <= modem_s2_ff;
            tx_was_busy_ff <= !tx_idle_now;
            if (rx_line_err_i) begin                                                     // R11
                line_pend_ff <= 1'b1;
            end else if (rd_line_control) begin
                line_pend_ff <= 1'b0;
            end
            if (modem_edge) begin                                                        // R10
                modem_pend_ff <= 1'b1;
            end else if (rd_line_control) begin
                modem_pend_ff <= 1'b0;
            end
            // Set on the pop that drains the last byte, or on a flush
            if (!wr_thr && tx_valid_o && (tx_ready_i && tx_count == 5'h01 || tx_flush)) begin
                txe_pend_ff <= 1'b1;                                                     // R12
            end else if (wr_thr || ack_txe) begin
                txe_pend_ff <= 1'b0;                                                     // R22
            end
            if (tx_idle_now && tx_was_busy_ff) begin                                     // R9
                txc_pend_ff <= 1'b1;
            end else if (wr_thr || ack_txc) begin
                txc_pend_ff <= 1'b0;
            end
        end
    end

    assign rdata_o        = rdata_ff;
    assign divisor_o      = {div_hi_ff, div_lo_ff};
    assign divisor_load_o = wr_divlo || wr_divhi;
    assign line_control_o = line_ctl_ff;

    sequence s_len_write;
        wr_thr && txq_ready && !tx_valid_o && !tx_flush;
    endsequence

    a_ident_fifo_bit: assert property (@(posedge clk_i) disable iff (reset_i)       // R14
        rd_i && sel_ident |=> rdata_o[FIFO_ON_BIT] == $past(fifo_on))
        else $error("fifo flag wrong");
    a_ident_no_irq: assert property (@(posedge clk_i) disable iff (reset_i)         // R15
        rd_i && sel_ident |=> rdata_o[0] == !$past(irq_o))
        else $error("pending bit wrong");
    a_unused_zero: assert property (@(posedge clk_i) disable iff (reset_i)          // R2
        rd_i && !(sel_data || sel_irqen || sel_ident || sel_line) |=> rdata_o == 8'h00)
        else $error("unused read not zero");
    a_line_first: assert property (@(posedge clk_i) disable iff (reset_i)           // R16
        rd_i && sel_ident && src_line |=> rdata_o[3:1] == CODE_LINE)
        else $error("line status not top");
    a_irqen_upper: assert property (@(posedge clk_i) disable iff (reset_i)          // R2
        irq_en_ff[7:5] == 3'h0)
        else $error("reserved enable bits set");
    a_tx_len_mask: assert property (@(posedge clk_i) disable iff (reset_i)          // R4
        s_len_write |=> tx_valid_o && (tx_data_o & ~$past(len_mask)) == 8'h00)
        else $error("tx upper bits leak");
    a_one_deep: assert property (@(posedge clk_i) disable iff (reset_i)             // R6
        !fifo_on && $past(!fifo_on) |-> tx_count <= 5'h01 && rx_count <= 5'h01)
        else $error("buffer deeper than one");
    a_dlab_divlo: assert property (@(posedge clk_i) disable iff (reset_i)           // R19
        wr_i && sel_data && dlab |=> div_lo_ff == $past(wdata_i) && $stable(tx_count))
        else $error("divisor write leaked");
    a_irq_level: assert property (@(posedge clk_i) disable iff (reset_i)            // R21
        any_src |-> irq_o && ident_val[0] == 1'b0 && ident_val[3:1] == cause)
        else $error("irq mismatch");
    a_txe_clear: assert property (@(posedge clk_i) disable iff (reset_i)            // R22
        wr_thr && txq_ready |=> !txe_pend_ff)
        else $error("tx empty not cleared");
endmodule

/* File: test/uartfe_far.sv */
`timescale 1ns/10ps
// Shifter side: drains the transmit queue and pushes received bytes
module uartfe_far (
    input  wire logic       clk_i,
    input  wire logic       stall_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o,
    output logic            tx_shift_empty_o,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    output logic [7:0]      rx_data_o
);
    logic [7:0] got_q[$];
    int         busy;
    initial begin
        busy = 0;
        rx_valid_o = 1'h0;
        rx_data_o = 8'h00;
    end
    // Takes a word only when idle, so a stall backs up the queue
    assign tx_ready_o       = !stall_i && busy == 0;
    assign tx_shift_empty_o = busy == 0;
    always @(posedge clk_i) begin
        if (busy > 0)
            busy <= busy - 1;
        if (tx_valid_i === 1'h1 && tx_ready_o) begin
            got_q.push_back(tx_data_i);
            busy <= 4;
        end
    end
    task automatic push(input logic [7:0] b);
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'h1;
        rx_data_o = b;
        while (rx_ready_i !== 1'h1) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'h0;
        // Released data no longer shows the byte
        rx_data_o = ~b;
    endtask
endmodule

/* File: test/uartfe_regs_tb.sv */
`timescale 1ns/10ps
module uartfe_regs_tb;
    import uartfe_pkg::*;
    logic        clk_i, reset_i, wr_i, rd_i, tx_valid_o, tx_ready_i, tx_shift_empty_i;
    logic        rx_valid_i, rx_ready_o, rx_timeout_i, rx_line_err_i, irq_o, stall, div_load;
    logic [7:0]  addr_i, wdata_i, rdata_o, tx_data_o, rx_data_i, d, line_control;
    logic [3:0]  modem_i;
    logic [15:0] divisor_o;
    int          bad_count, n_tests, cycles, loads;

    uartfe_regs dut_u (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o), .tx_shift_empty_i(tx_shift_empty_i),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .rx_data_i(rx_data_i),
        .rx_timeout_i(rx_timeout_i), .rx_line_err_i(rx_line_err_i), .modem_i(modem_i),
        .divisor_o(divisor_o), .divisor_load_o(div_load), .line_control_o(line_control), .irq_o(irq_o));
    uartfe_far far_u (.clk_i(clk_i), .stall_i(stall), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .tx_shift_empty_o(tx_shift_empty_i),
        .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o), .rx_data_o(rx_data_i));

    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (div_load === 1'h1)
            loads <= loads + 1;
        if (cycles == 8000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        #1;
        addr_i = a;
        wdata_i = v;
        wr_i = 1'h1;
        @(posedge clk_i);
        #1;
        wr_i = 1'h0;
    endtask
    // Read data lands one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        #1;
        addr_i = a;
        rd_i = 1'h1;
        @(posedge clk_i);
        #1;
        rd_i = 1'h0;
        v = rdata_o;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] v;
        rd(a, v);
        chk(nm, {24'h0, e}, {24'h0, v});
    endtask
    task automatic tx_expect(input int n, input logic [7:0] b0, input string nm);
        chk({nm, " count"}, n, far_u.got_q.size());
        for (int i = 0; i < n && far_u.got_q.size() > 0; i++)
            chk(nm, {24'h0, b0 + i[7:0]}, {24'h0, far_u.got_q.pop_front()});
        far_u.got_q.delete();
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    initial begin
        clk_i = 1'h0; reset_i = 1'h1; addr_i = 8'h00; wr_i = 1'h0; rd_i = 1'h0;
        wdata_i = 8'h00; rx_timeout_i = 1'h0; rx_line_err_i = 1'h0; modem_i = 4'h0;
        stall = 1'h0; bad_count = 0; n_tests = 0; cycles = 0; loads = 0;
        ticks(16);
        reset_i = 1'h0;
        chk("irq", 0, irq_o);
        chk("divisor", {DIVHI_RST, DIVLO_RST}, divisor_o);
        rdchk(ADDR_IRQEN, IRQEN_RST, "enable");
        rdchk(ADDR_IDENT, IDENT_RST, "ident");
        wr(8'h50, 8'hff);
        rdchk(8'h50, 8'h00, "unmapped");
        wr(ADDR_IRQEN, 8'he0);
        rdchk(ADDR_IRQEN, 8'h00, "enable reserved");
        wr(ADDR_LINE, 8'h83);
        chk("line control", 8'h83, line_control);
        wr(ADDR_DATA, 8'h34);
        wr(ADDR_IRQEN, 8'h12);
        chk("divisor", 16'h1234, divisor_o);
        chk("divisor loads", 2, loads);
        wr(ADDR_LINE, 8'h03);
        rdchk(ADDR_IRQEN, 8'h00, "enable after divisor");
        tx_expect(0, 8'h00, "divisor write");
        // Queue off: second byte has nowhere to go
        stall = 1'h1;
        wr(ADDR_DATA, 8'ha5);
        wr(ADDR_DATA, 8'h5a);
        stall = 1'h0;
        ticks(12);
        tx_expect(1, 8'ha5, "tx one deep");
        far_u.push(8'h3c);
        chk("rx ready one deep", 0, rx_ready_o);
        rdchk(ADDR_DATA, 8'h3c, "rx byte");
        chk("rx ready popped", 1, rx_ready_o);
        wr(ADDR_IDENT, 8'h07);
        rdchk(ADDR_IDENT, 8'h81, "ident fifo on");
        stall = 1'h1;
        for (int i = 0; i < 17; i++)
            wr(ADDR_DATA, 8'h10 + i[7:0]);
        stall = 1'h0;
        ticks(100);
        tx_expect(16, 8'h10, "tx fifo");
        for (int i = 0; i < 16; i++)
            far_u.push(8'h40 + i[7:0]);
        chk("rx full", 0, rx_ready_o);
        for (int i = 0; i < 16; i++)
            rdchk(ADDR_DATA, 8'h40 + i[7:0], "rx fifo");
        wr(ADDR_LINE, 8'h00);
        wr(ADDR_DATA, 8'hff);
        ticks(8);
        tx_expect(1, 8'h1f, "tx 5 bit");
        far_u.push(8'hff);
        rdchk(ADDR_DATA, 8'h1f, "rx 5 bit");
        wr(ADDR_LINE, 8'h01);
        wr(ADDR_DATA, 8'hff);
        ticks(8);
        tx_expect(1, 8'h3f, "tx 6 bit");
        wr(ADDR_LINE, 8'h02);
        far_u.push(8'hff);
        rdchk(ADDR_DATA, 8'h7f, "rx 7 bit");
        wr(ADDR_LINE, 8'h03);
        // All five sources at once; modem status clears with the line-control read, the rest are serviced one by one
        wr(ADDR_IRQEN, 8'h1f);
        wr(ADDR_DATA, 8'h66);
        far_u.push(8'h77);
        rx_line_err_i = 1'h1;
        ticks(1);
        rx_line_err_i = 1'h0;
        modem_i = 4'h1;
        ticks(10);
        tx_expect(1, 8'h66, "tx irq byte");
        chk("irq pending", 1, irq_o);
        rdchk(ADDR_IDENT, {4'h8, CODE_LINE, 1'h0}, "ident line");
        rd(ADDR_LINE, d);
        rx_timeout_i = 1'h1;
        rdchk(ADDR_IDENT, {4'h8, CODE_RXRDY, 1'h0}, "ident rx");
        rdchk(ADDR_DATA, 8'h77, "rx irq byte");
        rx_timeout_i = 1'h0;
        rdchk(ADDR_IDENT, {4'h8, CODE_TXC, 1'h0}, "ident tx done");
        rdchk(ADDR_IDENT, {4'h8, CODE_TXE, 1'h0}, "ident tx empty");
        rdchk(ADDR_IDENT, 8'h81, "ident idle");
        chk("irq idle", 0, irq_o);
        modem_i = 4'h0;
        ticks(8);
        rdchk(ADDR_IDENT, {4'h8, CODE_MODEM, 1'h0}, "ident modem");
        rd(ADDR_LINE, d);
        rdchk(ADDR_IDENT, 8'h81, "ident modem cleared");
        // Trigger of four: one byte alone only shows as a time-out
        wr(ADDR_IDENT, 8'h47);
        far_u.push(8'h21);
        rdchk(ADDR_IDENT, 8'h81, "below trigger");
        rx_timeout_i = 1'h1;
        ticks(2);
        rdchk(ADDR_IDENT, {4'h8, CODE_TOUT, 1'h0}, "ident timeout");
        rx_timeout_i = 1'h0;
        rdchk(ADDR_DATA, 8'h21, "rx trigger byte");
        // Trigger of eight, then fourteen on the same queue
        wr(ADDR_IDENT, 8'h87);
        for (int i = 0; i < 7; i++)
            far_u.push(8'h50 + i[7:0]);
        rdchk(ADDR_IDENT, 8'h81, "below trigger 8");
        far_u.push(8'h57);
        rdchk(ADDR_IDENT, {4'h8, CODE_RXRDY, 1'h0}, "ident trigger 8");
        wr(ADDR_IDENT, 8'hc7);
        rdchk(ADDR_IDENT, 8'h81, "below trigger 14");
        for (int i = 8; i < 14; i++)
            far_u.push(8'h50 + i[7:0]);
        rdchk(ADDR_IDENT, {4'h8, CODE_RXRDY, 1'h0}, "ident trigger 14");
        for (int i = 0; i < 14; i++)
            rdchk(ADDR_DATA, 8'h50 + i[7:0], "rx trigger 14");
        wr(ADDR_IRQEN, 8'h00);
        modem_i = 4'h2;
        ticks(8);
        chk("irq masked", 0, irq_o);
        rdchk(ADDR_IDENT, 8'h81, "ident masked");
        wr(ADDR_IDENT, 8'h00);
        rdchk(ADDR_IDENT, 8'h01, "ident fifo off");
        wr(ADDR_IRQEN, 8'h0a);
        reset_i = 1'h1;
        ticks(2);
        reset_i = 1'h0;
        rdchk(ADDR_IRQEN, IRQEN_RST, "enable after reset");
        report_and_stop();
    end
endmodule
